// *** uart_efc_pkg.sv ***
// Constants and carrier types for the enhanced-feature control block.
package uart_efc_pkg;
  // Register byte addresses on the APB.
  localparam logic [5:0] ADDR_IER = 6'h00;
  localparam logic [5:0] ADDR_ISR = 6'h04;
  localparam logic [5:0] ADDR_FCR = 6'h08;
  localparam logic [5:0] ADDR_LCR = 6'h0C;
  localparam logic [5:0] ADDR_MCR = 6'h10;
  localparam logic [5:0] ADDR_LSR = 6'h14;
  localparam logic [5:0] ADDR_MSR = 6'h18;
  localparam logic [5:0] ADDR_SPR = 6'h1C;
  localparam logic [5:0] ADDR_EFR = 6'h20;
  localparam logic [5:0] ADDR_RDY = 6'h24;
  localparam logic [5:0] ADDR_FEATURE_CONTROL = 6'h28;
  localparam logic [5:0] ADDR_TRG = 6'h2C;
  localparam logic [5:0] ADDR_XOFF2 = 6'h30;
  // Reset values.
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_LSR = 8'h60;
  localparam logic [7:0] RST_ISR = 8'h01;
  // Field positions.
  localparam int EFR_ENH = 4;
  localparam int EFR_SPECIAL = 5;
  localparam int EFR_AUTO_RTS = 6;
  localparam int EFR_AUTO_CTS = 7;
  localparam int FEATURE_CONTROL_IRDA_POL = 2;
  localparam int FEATURE_CONTROL_TX_INT = 3;
  localparam int FEATURE_CONTROL_REG_MODE = 6;
  localparam int FEATURE_CONTROL_TRG_SEL = 7;
  localparam int ENHANCED_MODE_SELECT_TX_COUNT = 0;
  localparam int ENHANCED_MODE_SELECT_ALT = 1;
  localparam int ISR_SPECIAL = 4;
  // FIFO depth and the four trigger tables, four levels each, table A in the low bytes.
  localparam logic [7:0] FIFO_DEPTH = 8'h80;
  localparam logic [127:0] TRIG_TABLES = 128'h78604008_70603010_38201008_3C381008;
  // Extra fill beyond the trigger for delay codes 01, 10, 11.
  localparam logic [7:0] RTS_DELAY_4 = 8'h04;
  localparam logic [7:0] RTS_DELAY_6 = 8'h06;
  localparam logic [7:0] RTS_DELAY_8 = 8'h08;

  typedef struct packed {
    logic [7:0] rx_count;
    logic [7:0] tx_count;
    logic rx_timeout;
    logic tx_hold_empty;
    logic tx_shift_empty;
  } fifo_status_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rx_char_type;
endpackage : uart_efc_pkg

// *** uart_enhanced_feature_control.sv ***
// Enhanced-feature control for one channel: registers, flow control, FIFO counts.
// Operation
// - Clearing enhanced enable saves, then zeroes, enhanced bits.
// - Setting enhanced enable restores saved enhanced bits.
// - After reset enhanced bits are zero.
// - Special character match sets status bit four.
// - Compare all eight XOFF2 bits with the received character.
// - Auto RTS throttles at level, releases below minus one.
// - Without auto RTS, RTS follows modem control.
// - Auto CTS stops transmitter while CTS high.
// - Low ready bits show transmit FIFO not full.
// - High ready bits show receive below trigger.
// - Delay field picks RTS throttle point.
// - Polarity bit selects IrDA receive inversion.
// - Interrupt-type bit selects transmit interrupt source.
// - Table field selects one of four tables.
// - Register mode turns scratch into count/mode register.
// - Mode select writable only in register mode.
// - Trigger-select bit routes trigger writes RX/TX.
// - Trigger write sets level, read returns count.
// - Count select picks receive or transmit count.
// - Alternate mode with transmit count select toggles counts, bit seven marks.
// - Reset clears registers, sets status defaults.
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ns
module uart_enhanced_feature_control
  import uart_efc_pkg::*;
(
  // Clock, reset, enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [5:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Datapath status and received characters.
  input wire fifo_status_type fifo_status,
  input wire rx_char_type rx_char,
  input wire logic cts_n,
  input wire logic [2:0] peer_tx_ready,
  input wire logic [2:0] peer_rx_ready,
  // Controls toward the datapath and pins.
  output logic rts_n,
  output logic tx_enable,
  output logic irda_rx_invert,
  output logic rx_irq,
  output logic tx_irq,
  output logic [7:0] fifo_ready_status
);

  logic [7:0] interrupt_enable_reg;
  logic [7:0] fifo_control_reg;
  logic [7:0] line_control_reg;
  logic [7:0] modem_control_reg;
  logic [7:0] line_status_reg;
  logic [7:0] scratch;
  logic [7:0] enhanced_feature_control;
  logic [7:0] feature_control;
  logic [7:0] enhanced_mode_select;
  logic [7:0] rx_trigger;
  logic [7:0] tx_trigger;
  logic [7:0] xoff2_char;
  logic [1:0] isr_enh;
  logic special_flag;
  logic cts_delta;
  logic cts_prev;
  logic cts_armed;
  logic alt_tx_turn;
  logic [3:0] saved_ier;
  logic [1:0] saved_isr;
  logic [1:0] saved_fcr;
  logic [2:0] saved_mcr;
  logic wr_en;
  logic rd_en;
  logic enh_on;
  logic [7:0] wdata;
  logic [7:0] table_level;
  logic [7:0] next_level;
  logic [7:0] rx_level;
  logic [7:0] rts_hold;
  logic [7:0] next_rdata;
  logic next_err;
  logic [7:0] count_read;

  assign wr_en = ce && psel && penable && pwrite && pready;
  assign rd_en = ce && psel && penable && !pwrite && pready;
  assign enh_on = enhanced_feature_control[EFR_ENH];
  assign wdata = pwdata[7:0];

  // Trigger level from the selected table, or the custom level once programmed.
  always_comb
  begin
    table_level = TRIG_TABLES[{feature_control[5:4], fifo_control_reg[7:6], 3'b000} +: 8];
    if (fifo_control_reg[7:6] == 2'b11)
      next_level = FIFO_DEPTH;
    else
      next_level = TRIG_TABLES[{feature_control[5:4], fifo_control_reg[7:6] + 2'b01, 3'b000} +: 8];
    rx_level = (rx_trigger != RST_ZERO) ? rx_trigger : table_level;
    if (rx_trigger != RST_ZERO)
      next_level = rx_level + RTS_DELAY_4;
    unique case (feature_control[1:0])
      2'b00: rts_hold = next_level;
      2'b01: rts_hold = rx_level + RTS_DELAY_4;
      2'b10: rts_hold = rx_level + RTS_DELAY_6;
      2'b11: rts_hold = rx_level + RTS_DELAY_8;
    endcase
  end

  // Count seen through the scratch address in register mode.
  always_comb
  begin
    count_read = enhanced_mode_select[ENHANCED_MODE_SELECT_TX_COUNT] ? fifo_status.tx_count
                                                     : fifo_status.rx_count;
    if (enhanced_mode_select[ENHANCED_MODE_SELECT_ALT] && enhanced_mode_select[ENHANCED_MODE_SELECT_TX_COUNT])
      count_read = alt_tx_turn ? {1'b1, fifo_status.tx_count[6:0]}
                               : {1'b0, fifo_status.rx_count[6:0]};
  end

  // Read data multiplexer; unmapped addresses answer with an error and zero data.
  always_comb
  begin
    next_err = 1'b0;
    next_rdata = RST_ZERO;
    unique case (paddr)
      ADDR_IER: next_rdata = interrupt_enable_reg;
      ADDR_ISR: next_rdata = {2'b00, isr_enh[1], special_flag, 3'b000, ~(rx_irq | tx_irq)};
      ADDR_FCR: next_rdata = fifo_control_reg;
      ADDR_LCR: next_rdata = line_control_reg;
      ADDR_MCR: next_rdata = modem_control_reg;
      ADDR_LSR: next_rdata = line_status_reg;
      ADDR_MSR: next_rdata = {3'b000, ~cts_n, 3'b000, cts_delta};
      ADDR_SPR: next_rdata = feature_control[FEATURE_CONTROL_REG_MODE] ? count_read : scratch;
      ADDR_EFR: next_rdata = enhanced_feature_control;
      ADDR_RDY: next_rdata = fifo_ready_status;
      ADDR_FEATURE_CONTROL: next_rdata = feature_control;
      ADDR_TRG: next_rdata = feature_control[FEATURE_CONTROL_TRG_SEL] ? fifo_status.tx_count
                                                           : fifo_status.rx_count;
      ADDR_XOFF2: next_rdata = xoff2_char;
      default: next_err = 1'b1;
    endcase
  end

  // One wait-free access phase: pready rises in the first access cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pready <= psel && !penable;
      prdata <= {24'h000000, next_rdata};
      pslverr <= psel && !penable && next_err;
    end
  end

  // Plain control registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_control_reg <= RST_ZERO;
      scratch <= RST_ZERO;
      enhanced_feature_control <= RST_ZERO;
      feature_control <= RST_ZERO;
      enhanced_mode_select <= RST_ZERO;
      rx_trigger <= RST_ZERO;
      tx_trigger <= RST_ZERO;
      xoff2_char <= RST_ZERO;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        ADDR_LCR: line_control_reg <= wdata;
        ADDR_SPR:
          if (feature_control[FEATURE_CONTROL_REG_MODE])
            enhanced_mode_select <= {4'h0, wdata[3:0]};
          else
            scratch <= wdata;
        ADDR_EFR: enhanced_feature_control <= wdata;
        ADDR_FEATURE_CONTROL: feature_control <= wdata;
        ADDR_TRG:
          if (feature_control[FEATURE_CONTROL_TRG_SEL])
            tx_trigger <= wdata;
          else
            rx_trigger <= wdata;
        ADDR_XOFF2: xoff2_char <= wdata;
        default: ;
      endcase
    end
  end

  // Registers that carry enhanced bits, with the save and restore around the enable.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      interrupt_enable_reg <= RST_ZERO;
      fifo_control_reg <= RST_ZERO;
      modem_control_reg <= RST_ZERO;
      isr_enh <= 2'b00;
      saved_ier <= 4'h0;
      saved_isr <= 2'b00;
      saved_fcr <= 2'b00;
      saved_mcr <= 3'b000;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        ADDR_IER: interrupt_enable_reg <= enh_on ? wdata
                                                 : {interrupt_enable_reg[7:4], wdata[3:0]};
        ADDR_FCR: fifo_control_reg <= enh_on ? wdata
                                             : {wdata[7:6], fifo_control_reg[5:4], wdata[3:0]};
        ADDR_MCR: modem_control_reg <= enh_on ? wdata : {modem_control_reg[7:5], wdata[4:0]};
        ADDR_ISR:
          if (enh_on)
            isr_enh <= wdata[5:4];
        ADDR_EFR:
          if (enh_on && !wdata[EFR_ENH])
          begin
            saved_ier <= interrupt_enable_reg[7:4];
            saved_isr <= isr_enh;
            saved_fcr <= fifo_control_reg[5:4];
            saved_mcr <= modem_control_reg[7:5];
            interrupt_enable_reg[7:4] <= 4'h0;
            isr_enh <= 2'b00;
            fifo_control_reg[5:4] <= 2'b00;
            modem_control_reg[7:5] <= 3'b000;
          end
          else if (!enh_on && wdata[EFR_ENH])
          begin
            interrupt_enable_reg[7:4] <= saved_ier;
            isr_enh <= saved_isr;
            fifo_control_reg[5:4] <= saved_fcr;
            modem_control_reg[7:5] <= saved_mcr;
          end
        default: ;
      endcase
    end
  end

  // Special character flag; a match in the same cycle as the status read is kept.
  // The host must clear the software flow selection while detection is on.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      special_flag <= 1'b0;
    else if (ce)
    begin
      if (enhanced_feature_control[EFR_SPECIAL] && rx_char.valid
          && rx_char.data == xoff2_char)
        special_flag <= 1'b1;
      else if (rd_en && paddr == ADDR_ISR)
        special_flag <= 1'b0;
    end
  end

  // Status mirrors: line status, CTS change, and the alternate count turn.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_status_reg <= RST_LSR;
      cts_delta <= 1'b0;
      cts_prev <= 1'b1;
      cts_armed <= 1'b0;
      alt_tx_turn <= 1'b0;
    end
    else if (ce)
    begin
      line_status_reg <= {1'b0, fifo_status.tx_hold_empty && fifo_status.tx_shift_empty,
                          fifo_status.tx_hold_empty, 4'h0, fifo_status.rx_count != RST_ZERO};
      // The first enabled edge after reset only loads the history, so a pin that
      // idles low is not reported as a change.
      cts_prev <= cts_n;
      cts_armed <= 1'b1;
      if (cts_armed && cts_n != cts_prev)
        cts_delta <= 1'b1;
      else if (rd_en && paddr == ADDR_MSR)
        cts_delta <= 1'b0;
      if (rd_en && paddr == ADDR_SPR && feature_control[FEATURE_CONTROL_REG_MODE])
        alt_tx_turn <= !alt_tx_turn;
    end
  end

  // Flow control, interrupts and the FIFO ready word.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rts_n <= 1'b1;
      tx_enable <= 1'b1;
      irda_rx_invert <= 1'b0;
      rx_irq <= 1'b0;
      tx_irq <= 1'b0;
      fifo_ready_status <= RST_ZERO;
    end
    else if (ce)
    begin
      if (!enhanced_feature_control[EFR_AUTO_RTS])
        rts_n <= !modem_control_reg[1];
      else if (fifo_status.rx_count >= rts_hold)
        rts_n <= 1'b1;
      else if (fifo_status.rx_count < rx_level - 8'h01)
        rts_n <= 1'b0;
      tx_enable <= !(enhanced_feature_control[EFR_AUTO_CTS] && cts_n);
      irda_rx_invert <= feature_control[FEATURE_CONTROL_IRDA_POL];
      rx_irq <= interrupt_enable_reg[0] && fifo_status.rx_count >= rx_level;
      tx_irq <= interrupt_enable_reg[1] && fifo_status.tx_hold_empty
                && (!feature_control[FEATURE_CONTROL_TX_INT] || fifo_status.tx_shift_empty);
      fifo_ready_status <= {peer_rx_ready,
                            fifo_status.rx_count < rx_level && !fifo_status.rx_timeout,
                            peer_tx_ready,
                            fifo_status.tx_count != FIFO_DEPTH};
    end
  end

  // Checks.
  sequence s_efr_write(logic bit4);
    wr_en && paddr == ADDR_EFR && wdata[EFR_ENH] == bit4;
  endsequence

  property p_latch;
    @(posedge pclk) disable iff (!presetn)
    enh_on ##0 s_efr_write(1'b0) |=> interrupt_enable_reg[7:4] == 4'h0
      && saved_ier == $past(interrupt_enable_reg[7:4]);
  endproperty
  a_latch: assert property (p_latch) else $error("enhanced bits not saved");

  property p_restore;
    @(posedge pclk) disable iff (!presetn)
    !enh_on ##0 s_efr_write(1'b1) |=> interrupt_enable_reg[7:4] == $past(saved_ier)
      && modem_control_reg[7:5] == $past(saved_mcr);
  endproperty
  a_restore: assert property (p_restore) else $error("enhanced bits not restored");

  property p_legacy;
    @(posedge pclk) disable iff (!presetn)
    !enh_on && !$past(enh_on) |-> interrupt_enable_reg[7:4] == 4'h0 && isr_enh == 2'b00;
  endproperty
  a_legacy: assert property (p_legacy) else $error("enhanced bits set in legacy mode");

  property p_special;
    @(posedge pclk) disable iff (!presetn)
    ce && enhanced_feature_control[EFR_SPECIAL] && rx_char.valid && rx_char.data == xoff2_char
      |=> special_flag;
  endproperty
  a_special: assert property (p_special) else $error("special match missed");

  property p_rts_follow;
    @(posedge pclk) disable iff (!presetn)
    ce && !enhanced_feature_control[EFR_AUTO_RTS] |=> rts_n == !$past(modem_control_reg[1]);
  endproperty
  a_rts_follow: assert property (p_rts_follow) else $error("rts not following");

  property p_rts_throttle;
    @(posedge pclk) disable iff (!presetn)
    ce && enhanced_feature_control[EFR_AUTO_RTS] && fifo_status.rx_count >= rts_hold |=> rts_n;
  endproperty
  a_rts_throttle: assert property (p_rts_throttle) else $error("rts not throttled");

  property p_cts;
    @(posedge pclk) disable iff (!presetn)
    ce && enhanced_feature_control[EFR_AUTO_CTS] && cts_n |=> !tx_enable;
  endproperty
  a_cts: assert property (p_cts) else $error("transmit not stopped");

  property p_tx_ready;
    @(posedge pclk) disable iff (!presetn)
    ce && fifo_status.tx_count == FIFO_DEPTH |=> !fifo_ready_status[0];
  endproperty
  a_tx_ready: assert property (p_tx_ready) else $error("full fifo shown ready");

  property p_tx_int;
    @(posedge pclk) disable iff (!presetn)
    ce && feature_control[FEATURE_CONTROL_TX_INT] && !fifo_status.tx_shift_empty |=> !tx_irq;
  endproperty
  a_tx_int: assert property (p_tx_int) else $error("early transmit interrupt");

endmodule : uart_enhanced_feature_control

// *** apb_host.sv ***
// APB master model standing in for the host processor.
`timescale 1ns/1ns
module apb_host
(
  // Clock.
  input wire logic pclk,
  // APB master side.
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [5:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready,
  // Raised when the slave never answers.
  output logic hung
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 6'h00;
    pwdata = 32'h00000000;
    hung = 1'b0;
  end

  // One idle edge after release keeps a back-to-back call from assigning psel twice at once.
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      hung <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
endmodule : apb_host

// *** tb_top.sv ***
// Self-checking bench for the enhanced-feature control block.
`timescale 1ns/1ns
module tb_top;
  import uart_efc_pkg::*;
  typedef struct packed {
    logic [3:0] src;
    logic [7:0] exp;
    logic [7:0] mask;
  } note_type;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, hung;
  logic [5:0] paddr;
  logic [31:0] pwdata, prdata;
  fifo_status_type fst = {8'h00, 8'h00, 1'b0, 1'b1, 1'b1};
  rx_char_type rxc = {1'b0, 8'h00};
  logic cts_n = 1'b0;
  logic [2:0] peer_tx_ready = 3'h0;
  logic [2:0] peer_rx_ready = 3'h0;
  logic rts_n, tx_enable, irda_rx_invert, rx_irq, tx_irq;
  logic [7:0] fifo_ready_status, got, lvl;
  logic smp = 1'b0;
  logic [31:0] rnd = 32'hDA6E37C1;
  note_type q[$];
  note_type nt;
  int n_mismatch = 0;
  int checks = 0;

  always #5 pclk = ~pclk;

  apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .hung(hung));

  uart_enhanced_feature_control uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fifo_status(fst), .rx_char(rxc), .cts_n(cts_n),
    .peer_tx_ready(peer_tx_ready), .peer_rx_ready(peer_rx_ready), .rts_n(rts_n),
    .tx_enable(tx_enable), .irda_rx_invert(irda_rx_invert), .rx_irq(rx_irq),
    .tx_irq(tx_irq), .fifo_ready_status(fifo_ready_status));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [3:0] s, input logic [5:0] a, input logic [7:0] e,
    input logic [7:0] m);
    q.push_back({s, e, m});
    host.xfer(1'b0, a, 8'h00);
  endtask : rd

  // Ports react one cycle after a cause, so three edges leave margin without a race.
  task automatic chk(input logic [3:0] s, input logic [7:0] e);
    repeat (3) @(posedge pclk);
    q.push_back({s, e, 8'hFF});
    smp <= 1'b1;
    @(posedge pclk);
    smp <= 1'b0;
  endtask : chk

  task automatic fr(input logic [7:0] rc, input logic [7:0] tc, input logic to,
    input logic erx, input logic etx);
    rnd = lfsr(rnd);
    peer_tx_ready <= rnd[2:0];
    peer_rx_ready <= rnd[5:3];
    fst.rx_count <= rc;
    fst.tx_count <= tc;
    fst.rx_timeout <= to;
    chk(4'd6, {rnd[5:3], erx, rnd[2:0], etx});
  endtask : fr

  task automatic send(input logic [7:0] d);
    rxc <= {1'b1, d};
    @(posedge pclk);
    rxc <= {1'b0, d};
  endtask : send

  task automatic done(input string name);
    $display("test %s done, %0d checks so far", name, checks);
  endtask : done

  always @(posedge pclk)
  begin
    if ((psel & penable & pready & ~pwrite) === 1'b1 || smp === 1'b1)
    begin
      checks++;
      if (q.size() == 0)
      begin
        n_mismatch++;
        $display("wrong value at %0t: result 0x%h with no note", $time, prdata[7:0]);
      end
      else
      begin
        nt = q.pop_front();
        case (nt.src)
          4'd0: got = prdata[7:0];
          4'd1: got = {7'h00, rts_n};
          4'd2: got = {7'h00, tx_enable};
          4'd3: got = {7'h00, irda_rx_invert};
          4'd4: got = {7'h00, rx_irq};
          4'd5: got = {7'h00, tx_irq};
          4'd6: got = fifo_ready_status;
          default: got = {7'h00, pslverr};
        endcase
        if ((got & nt.mask) !== (nt.exp & nt.mask))
        begin
          n_mismatch++;
          $display("wrong value at %0t: got 0x%h expected 0x%h", $time, got, nt.exp);
        end
      end
    end
  end

  always @(posedge pclk)
  begin
    if (hung === 1'b1)
    begin
      n_mismatch++;
      stop_test();
    end
  end

  initial
  begin
    repeat (50000) @(posedge pclk);
    n_mismatch++;
    stop_test();
  end

  initial
  begin
    logic [7:0] r;
    logic [7:0] cnt [4];
    logic [7:0] ex [4];
    cnt = '{8'h0F, 8'h10, 8'h07, 8'h06};
    ex = '{8'h00, 8'h01, 8'h01, 8'h00};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(4'd1, 8'h01);
    chk(4'd2, 8'h01);
    rd(4'd0, ADDR_IER, 8'h00, 8'hFF);
    rd(4'd0, ADDR_ISR, RST_ISR, 8'hFF);
    rd(4'd0, ADDR_LCR, 8'h00, 8'hFF);
    rd(4'd0, ADDR_MCR, 8'h00, 8'hFF);
    rd(4'd0, ADDR_LSR, RST_LSR, 8'hFF);
    rd(4'd0, ADDR_MSR, 8'h00, 8'h0F);
    rd(4'd0, ADDR_EFR, 8'h00, 8'hFF);
    rd(4'd0, ADDR_FEATURE_CONTROL, 8'h00, 8'hFF);
    rd(4'd7, 6'h34, 8'h01, 8'h01);
    done("reset");
    wr(ADDR_EFR, 8'h10);
    wr(ADDR_IER, 8'hF0);
    wr(ADDR_MCR, 8'hE0);
    rd(4'd0, ADDR_IER, 8'hF0, 8'hF0);
    wr(ADDR_EFR, 8'h00);
    rd(4'd0, ADDR_IER, 8'h00, 8'hF0);
    rd(4'd0, ADDR_MCR, 8'h00, 8'hE0);
    wr(ADDR_IER, 8'hA0);
    wr(ADDR_EFR, 8'h10);
    rd(4'd0, ADDR_IER, 8'hF0, 8'hF0);
    rd(4'd0, ADDR_MCR, 8'hE0, 8'hE0);
    wr(ADDR_MCR, 8'h00);
    wr(ADDR_IER, 8'h00);
    done("latch");
    wr(ADDR_XOFF2, 8'h5A);
    wr(ADDR_EFR, 8'h30);
    send(8'h5B);
    rd(4'd0, ADDR_ISR, 8'h00, 8'h10);
    send(8'h5A);
    rd(4'd0, ADDR_ISR, 8'h10, 8'h10);
    done("special");
    wr(ADDR_EFR, 8'h10);
    fst.rx_count <= 8'h7F;
    wr(ADDR_MCR, 8'h02);
    chk(4'd1, 8'h00);
    wr(ADDR_MCR, 8'h00);
    chk(4'd1, 8'h01);
    wr(ADDR_MCR, 8'h02);
    fst.rx_count <= 8'h00;
    wr(ADDR_EFR, 8'h50);
    for (int i = 0; i < 4; i++)
    begin
      fst.rx_count <= cnt[i];
      chk(4'd1, ex[i]);
    end
    for (int d = 1; d < 4; d++)
    begin
      wr(ADDR_FEATURE_CONTROL, d[7:0]);
      lvl = 8'h08 + ((d == 1) ? RTS_DELAY_4 : (d == 2) ? RTS_DELAY_6 : RTS_DELAY_8);
      fst.rx_count <= lvl - 8'h01;
      chk(4'd1, 8'h00);
      fst.rx_count <= lvl;
      chk(4'd1, 8'h01);
      fst.rx_count <= 8'h06;
      chk(4'd1, 8'h00);
    end
    wr(ADDR_FEATURE_CONTROL, 8'h00);
    wr(ADDR_FCR, 8'hC1);
    fst.rx_count <= 8'h7F;
    chk(4'd1, 8'h00);
    fst.rx_count <= FIFO_DEPTH;
    chk(4'd1, 8'h01);
    done("rts");
    wr(ADDR_EFR, 8'h90);
    cts_n <= 1'b1;
    chk(4'd2, 8'h00);
    cts_n <= 1'b0;
    chk(4'd2, 8'h01);
    wr(ADDR_EFR, 8'h10);
    cts_n <= 1'b1;
    chk(4'd2, 8'h01);
    cts_n <= 1'b0;
    done("cts");
    wr(ADDR_IER, 8'h01);
    wr(ADDR_FCR, 8'h41);
    for (int t = 0; t < 4; t++)
    begin
      wr(ADDR_FEATURE_CONTROL, {2'b00, t[1:0], 4'h0});
      lvl = TRIG_TABLES[(t * 4 + 1) * 8 +: 8];
      fst.rx_count <= lvl - 8'h01;
      chk(4'd4, 8'h00);
      fst.rx_count <= lvl;
      chk(4'd4, 8'h01);
    end
    wr(ADDR_FEATURE_CONTROL, 8'h00);
    fr(8'h00, FIFO_DEPTH, 1'b0, 1'b1, 1'b0);
    fr(8'h30, 8'h7F, 1'b0, 1'b0, 1'b1);
    fr(8'h00, 8'h00, 1'b1, 1'b0, 1'b1);
    fst.rx_timeout <= 1'b0;
    done("ready");
    wr(ADDR_TRG, 8'h20);
    wr(ADDR_FEATURE_CONTROL, 8'h80);
    wr(ADDR_TRG, 8'h05);
    fst.rx_count <= 8'h1F;
    chk(4'd4, 8'h00);
    fst.rx_count <= 8'h20;
    chk(4'd4, 8'h01);
    fst.rx_count <= 8'h22;
    fst.tx_count <= 8'h33;
    rd(4'd0, ADDR_TRG, 8'h33, 8'hFF);
    wr(ADDR_FEATURE_CONTROL, 8'h00);
    rd(4'd0, ADDR_TRG, 8'h22, 8'hFF);
    done("trigger");
    rnd = lfsr(rnd);
    r = rnd[7:0];
    wr(ADDR_SPR, r);
    rd(4'd0, ADDR_SPR, r, 8'hFF);
    wr(ADDR_FEATURE_CONTROL, 8'h40);
    rd(4'd0, ADDR_SPR, 8'h22, 8'hFF);
    wr(ADDR_SPR, 8'h01);
    rd(4'd0, ADDR_SPR, 8'h33, 8'hFF);
    wr(ADDR_SPR, 8'h03);
    rd(4'd0, ADDR_SPR, 8'h22, 8'hFF);
    rd(4'd0, ADDR_SPR, 8'hB3, 8'hFF);
    wr(ADDR_FEATURE_CONTROL, 8'h00);
    rd(4'd0, ADDR_SPR, r, 8'hFF);
    done("count");
    wr(ADDR_FEATURE_CONTROL, 8'h04);
    chk(4'd3, 8'h01);
    wr(ADDR_FEATURE_CONTROL, 8'h00);
    chk(4'd3, 8'h00);
    wr(ADDR_IER, 8'h02);
    fst.tx_shift_empty <= 1'b0;
    chk(4'd5, 8'h01);
    wr(ADDR_FEATURE_CONTROL, 8'h08);
    chk(4'd5, 8'h00);
    fst.tx_shift_empty <= 1'b1;
    chk(4'd5, 8'h01);
    ce <= 1'b0;
    fst.tx_shift_empty <= 1'b0;
    chk(4'd5, 8'h01);
    ce <= 1'b1;
    chk(4'd5, 8'h00);
    done("modes");
    stop_test();
  end
endmodule : tb_top
